/* core/mda_history.sv */
// ten-entry alarm history, newest at index 0
// assumes the storage is backed by non-volatile cells outside sys_rst
`timescale 1ns/1ps
module mda_history
  import mda_pkg::*;
#(
  parameter int unsigned DEPTH = HIST_DEPTH
) (
  // clock
  input  wire logic                  clock,
  // control
  input  wire logic                  log_push,
  input  wire logic [CODE_W-1:0]     log_code,
  input  wire logic                  hist_clear,
  // read port
  input  wire logic [HIST_IDX_W-1:0] rd_index,
  output logic      [CODE_W-1:0]     rd_code,
  output logic      [HIST_IDX_W-1:0] hist_count
);

  // storage is not reset: contents survive an alarm clear and sys_rst
  logic [CODE_W-1:0]     mem_reg [DEPTH];
  logic [HIST_IDX_W-1:0] count_reg = '0;
  logic [CODE_W-1:0]     rd_reg    = CODE_NONE;

  // ****************************************************************
  // shift in newest, drop oldest when full
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : g_ent
      always_ff @(posedge clock) begin
        if (hist_clear) begin
          mem_reg[g] <= CODE_NONE;
        end else if (log_push) begin
          mem_reg[g] <= (g == 0) ? log_code : mem_reg[(g == 0) ? 0 : g-1];
        end
      end
    end
  endgenerate

  always_ff @(posedge clock) begin
    if (hist_clear) begin
      count_reg <= '0;
    end else if (log_push && count_reg != HIST_IDX_W'(DEPTH)) begin
      count_reg <= count_reg + 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    rd_reg <= (rd_index < count_reg) ? mem_reg[rd_index] : CODE_NONE;
  end

  assign rd_code    = rd_reg;
  assign hist_count = count_reg;

endmodule

/* core/mda_pkg.sv */
// constants and types shared by the motor driver alarm handling block
// assumes a single 50 MHz clock domain
package mda_pkg;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int unsigned CLOCK_HZ      = 50_000_000;
  localparam int unsigned BLINK_MS      = 250;
  localparam int unsigned BLINK_CYCLES  = (CLOCK_HZ / 1000) * BLINK_MS;

  // ****************************************************************
  // widths and sizes
  // ****************************************************************
  localparam int unsigned CODE_W        = 8;
  localparam int unsigned SPEED_W       = 16;
  localparam int unsigned HIST_DEPTH    = 10;
  localparam int unsigned HIST_IDX_W    = 4;

  // ****************************************************************
  // reset values and encodings
  // ****************************************************************
  localparam logic [7:0]  CODE_NONE     = 8'h00;
  localparam logic        DIR_POS_CCW   = 1'b0;
  localparam logic        DIR_POS_CW    = 1'b1;

  typedef enum logic [1:0] {
    MDA_CLR_PIN,
    MDA_CLR_PANEL,
    MDA_CLR_SOFT,
    MDA_CLR_NONE
  } mda_clr_src_e;

endpackage

/* core/mda_sync.sv */
// two flip-flop synchroniser for a group of pin inputs
// assumes the inputs are asynchronous to clock
`timescale 1ns/1ps
module mda_sync
  import mda_pkg::*;
#(
  parameter int unsigned WIDTH = 3
) (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             sys_rst,
  // data
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      stage1_reg <= '0;
      stage2_reg <= '0;
    end else begin
      stage1_reg <= async_in;
      stage2_reg <= stage1_reg;
    end
  end

  assign sync_out = stage2_reg;

endmodule

/* core/mda_top.sv */
// alarm and protection handling of a brushless motor driver
// assumes run and clear pins asynchronous; panel and software strobes on clock
`timescale 1ns/1ps
module mda_top
  import mda_pkg::*;
#(
  parameter int unsigned BLINK_COUNT = BLINK_CYCLES
) (
  // clock and reset
  input  wire logic                  clock,
  input  wire logic                  sys_rst,
  // host pins
  input  wire logic                  forward_run_input,
  input  wire logic                  reverse_run_input,
  input  wire logic                  fault_clear_input,
  // alarm detection
  input  wire logic                  alarm_detect,
  input  wire logic [CODE_W-1:0]     alarm_code_in,
  input  wire logic                  alarm_nonresettable,
  input  wire logic                  info_present,
  // clear requests
  input  wire logic                  panel_clear_cmd,
  input  wire logic                  soft_clear_cmd,
  input  wire logic                  power_on_clear,
  // history access
  input  wire logic                  panel_hist_clear,
  input  wire logic                  soft_hist_clear,
  input  wire logic [HIST_IDX_W-1:0] hist_rd_index,
  output logic      [CODE_W-1:0]     hist_rd_code,
  output logic      [HIST_IDX_W-1:0] hist_count,
  // configuration
  input  wire logic                  dir_param,
  input  wire logic [SPEED_W-1:0]    speed_upper,
  input  wire logic [SPEED_W-1:0]    speed_lower,
  input  wire logic [SPEED_W-1:0]    speed_request,
  // panel editing
  input  wire logic                  edit_lock,
  input  wire logic                  panel_edit_enable,
  input  wire logic                  soft_session,
  input  wire logic                  dial_write,
  input  wire logic [SPEED_W-1:0]    dial_value,
  input  wire logic                  local_mode_req,
  output logic                       dial_accept,
  output logic      [SPEED_W-1:0]    panel_setting,
  output logic                       local_mode,
  output logic                       edit_refused,
  // outputs to motor and panel
  output logic                       fault_free,
  output logic                       motor_enable,
  output logic                       motor_dir_cw,
  output logic      [SPEED_W-1:0]    speed_command,
  output logic      [CODE_W-1:0]     display_code,
  output logic                       alarm_led
);

  // ****************************************************************
  // pin synchronisation
  // ****************************************************************
  logic [2:0] pins_sync;

  mda_sync #(
    .WIDTH (3)
  ) u_sync (
    .clock    (clock),
    .sys_rst  (sys_rst),
    .async_in ({fault_clear_input, reverse_run_input, forward_run_input}),
    .sync_out (pins_sync)
  );

  wire fwd_s   = pins_sync[0];
  wire rev_s   = pins_sync[1];
  wire clr_s   = pins_sync[2];

  logic clr_prev_reg;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      clr_prev_reg <= 1'b1;
    end else begin
      clr_prev_reg <= clr_s;
    end
  end

  // ****************************************************************
  // clear decoding
  // ****************************************************************
  wire run_any   = fwd_s | rev_s;
  wire clr_edge  = clr_s & ~clr_prev_reg;
  wire pin_clear = clr_edge & ~run_any;
  wire req_clear = pin_clear | panel_clear_cmd | soft_clear_cmd;

  // ****************************************************************
  // alarm state
  // ****************************************************************
  logic              alarm_reg;
  logic              nonres_reg;
  logic [CODE_W-1:0] code_reg;
  logic              alarm_next;
  logic              nonres_next;
  logic [CODE_W-1:0] code_next;

  wire new_alarm  = alarm_detect & ~alarm_reg;
  wire clear_ok   = power_on_clear | (req_clear & ~nonres_reg);

  always_comb begin
    alarm_next  = alarm_reg;
    nonres_next = nonres_reg;
    code_next   = code_reg;
    if (new_alarm) begin
      alarm_next  = 1'b1;
      nonres_next = alarm_nonresettable;
      code_next   = alarm_code_in;
    end else if (alarm_reg && clear_ok) begin
      alarm_next  = 1'b0;
      nonres_next = 1'b0;
      code_next   = CODE_NONE;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      alarm_reg  <= 1'b0;
      nonres_reg <= 1'b0;
      code_reg   <= CODE_NONE;
    end else begin
      alarm_reg  <= alarm_next;
      nonres_reg <= nonres_next;
      code_reg   <= code_next;
    end
  end

  // ****************************************************************
  // alarm history
  // ****************************************************************
  wire hist_clr = panel_hist_clear | soft_hist_clear;

  mda_history #(
    .DEPTH (HIST_DEPTH)
  ) u_hist (
    .clock      (clock),
    .log_push   (new_alarm),
    .log_code   (alarm_code_in),
    .hist_clear (hist_clr),
    .rd_index   (hist_rd_index),
    .rd_code    (hist_rd_code),
    .hist_count (hist_count)
  );

  // ****************************************************************
  // blink divider
  // ****************************************************************
  logic [31:0] blink_cnt_reg;
  logic        blink_reg;
  wire         blink_tick = (blink_cnt_reg == BLINK_COUNT - 1);

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      blink_cnt_reg <= '0;
      blink_reg     <= 1'b0;
    end else if (blink_tick) begin
      blink_cnt_reg <= '0;
      blink_reg     <= ~blink_reg;
    end else begin
      blink_cnt_reg <= blink_cnt_reg + 32'h0000_0001;
    end
  end

  // ****************************************************************
  // speed clamp and run decision
  // ****************************************************************
  wire         run_one   = fwd_s ^ rev_s;
  wire [SPEED_W-1:0] lim_lo = (speed_request < speed_lower) ? speed_lower
                                                            : speed_request;
  wire [SPEED_W-1:0] lim_hi = (lim_lo > speed_upper) ? speed_upper : lim_lo;
  wire         run_go    = run_one & ~alarm_reg;

  // positive = forward; dir_param picks which rotation is positive
  wire         dir_cw    = (dir_param == DIR_POS_CW) ? fwd_s : rev_s;

  logic              run_reg;
  logic              dir_reg;
  logic [SPEED_W-1:0] speed_reg;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      run_reg   <= 1'b0;
      dir_reg   <= 1'b0;
      speed_reg <= '0;
    end else begin
      run_reg   <= run_go & ~new_alarm;
      dir_reg   <= dir_cw;
      speed_reg <= (run_go & ~new_alarm) ? lim_hi : '0;
    end
  end

  // ****************************************************************
  // panel editing
  // ****************************************************************
  wire edit_ok   = ~edit_lock & panel_edit_enable & ~soft_session;
  wire dial_take = dial_write & edit_ok;
  wire refuse    = (dial_write & ~edit_ok) | (local_mode_req & soft_session);

  logic [SPEED_W-1:0] setting_reg;
  logic               local_reg;
  logic               refused_reg;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      setting_reg <= '0;
      local_reg   <= 1'b0;
      refused_reg <= 1'b0;
    end else begin
      if (dial_take) begin
        setting_reg <= dial_value;
      end
      if (local_mode_req && !soft_session) begin
        local_reg <= ~local_reg;
      end
      refused_reg <= refuse;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign fault_free    = ~alarm_reg;
  assign motor_enable  = run_reg;
  assign motor_dir_cw  = dir_reg;
  assign speed_command = speed_reg;
  assign display_code  = code_reg;
  assign alarm_led     = (alarm_reg | info_present) & blink_reg;
  assign dial_accept   = dial_take;
  assign panel_setting = setting_reg;
  assign local_mode    = local_reg;
  assign edit_refused  = refused_reg;

  // ****************************************************************
  // assertions
  // ****************************************************************
  AST_ALARM_OUTPUTS: assert property (@(posedge clock) disable iff (sys_rst)
    new_alarm |=> (!fault_free && !motor_enable && display_code == $past(alarm_code_in)))
    else $error("alarm outputs not together");
  AST_HELD_CLEAR: assert property (@(posedge clock) disable iff (sys_rst)
    (clr_s && clr_prev_reg && !panel_clear_cmd && !soft_clear_cmd && !power_on_clear
     && alarm_reg) |=> alarm_reg)
    else $error("held clear level cleared alarm");
  AST_RUN_BLOCKS_CLEAR: assert property (@(posedge clock) disable iff (sys_rst)
    (alarm_reg && run_any && !panel_clear_cmd && !soft_clear_cmd && !power_on_clear)
    |=> alarm_reg)
    else $error("clear taken while running");
  AST_SOFT_CLEAR: assert property (@(posedge clock) disable iff (sys_rst)
    (alarm_reg && !nonres_reg && soft_clear_cmd && !alarm_detect) |=> !alarm_reg)
    else $error("software clear ignored");
  AST_NONRES_KEPT: assert property (@(posedge clock) disable iff (sys_rst)
    (alarm_reg && nonres_reg && !power_on_clear) |=> alarm_reg)
    else $error("non-resettable alarm cleared");
  AST_HIST_COUNT: assert property (@(posedge clock) disable iff (sys_rst)
    hist_count <= HIST_IDX_W'(HIST_DEPTH))
    else $error("history overflow");
  AST_HIST_KEEP: assert property (@(posedge clock) disable iff (sys_rst)
    (!panel_hist_clear && !soft_hist_clear && !new_alarm) |=> $stable(hist_count))
    else $error("history changed without push or clear");
  AST_SPEED_HI: assert property (@(posedge clock) disable iff (sys_rst)
    motor_enable |-> speed_command <= $past(speed_upper))
    else $error("speed above upper limit");
  AST_SPEED_LO: assert property (@(posedge clock) disable iff (sys_rst)
    (motor_enable && $past(speed_lower) <= $past(speed_upper))
    |-> speed_command >= $past(speed_lower))
    else $error("speed below lower limit");
  AST_NO_RUN_BOTH: assert property (@(posedge clock) disable iff (sys_rst)
    (fwd_s == rev_s) |=> !motor_enable)
    else $error("motor runs without one run input");
  AST_SESSION_EDIT: assert property (@(posedge clock) disable iff (sys_rst)
    soft_session |-> !dial_accept)
    else $error("panel edit during session");

  COV_ALARM:      cover property (@(posedge clock) disable iff (sys_rst) new_alarm);
  COV_PIN_CLEAR:  cover property (@(posedge clock) disable iff (sys_rst)
    alarm_reg && pin_clear ##1 !alarm_reg);
  COV_HIST_FULL:  cover property (@(posedge clock) disable iff (sys_rst)
    hist_count == HIST_IDX_W'(HIST_DEPTH));
  COV_RUN:        cover property (@(posedge clock) disable iff (sys_rst) motor_enable);

endmodule

/* test/mda_host.sv */
// host model driving the run and clear pins of the driver
// assumes bench commands change on the clock edge
`timescale 1ns/1ps
module mda_host (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       sys_rst,
  // commands from the bench
  input  wire logic [1:0] run_sel,
  input  wire logic       clr_req,
  input  wire logic       brk,
  // pins to the driver
  output logic            forward_run_input,
  output logic            reverse_run_input,
  output logic            fault_clear_input
);
  logic hold;
  logic runs_on;
  assign hold    = clr_req & ~brk;
  assign runs_on = forward_run_input | reverse_run_input;
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      forward_run_input <= 1'b0;
      reverse_run_input <= 1'b0;
      fault_clear_input <= 1'b0;
    end else begin
      forward_run_input <= run_sel[0] & ~hold;
      reverse_run_input <= run_sel[1] & ~hold;
      fault_clear_input <= clr_req & (brk | ~runs_on);
    end
  end
endmodule

/* test/motor_driver_alarm_handling_bench.sv */
// self-checking bench for the alarm handling block
// assumes mda_host drives the run and clear pins
`timescale 1ns/1ps
module motor_driver_alarm_handling_bench;
  import mda_pkg::*;
  localparam int BL = 4;
  logic                  clock = 0;
  logic                  sys_rst = 1;
  logic [1:0]            run_sel = 0;
  logic                  clr_req = 0;
  logic                  brk = 0;
  logic [7:0]            stb = 0;
  logic [CODE_W-1:0]     alarm_code_in = 0;
  logic                  alarm_nonresettable = 0;
  logic                  info_present = 0;
  logic                  dir_param = 0;
  logic                  edit_lock = 0;
  logic                  panel_edit_enable = 1;
  logic                  soft_session = 0;
  logic [HIST_IDX_W-1:0] hist_rd_index = 0;
  logic [SPEED_W-1:0]    speed_upper = 0;
  logic [SPEED_W-1:0]    speed_lower = 0;
  logic [SPEED_W-1:0]    speed_request = 0;
  logic [SPEED_W-1:0]    dial_value = 0;
  logic [SPEED_W-1:0]    set_m;
  logic [SPEED_W-1:0]    panel_setting, speed_command;
  logic [CODE_W-1:0]     hist_rd_code, display_code;
  logic [HIST_IDX_W-1:0] hist_count;
  logic                  forward_run_input, reverse_run_input, fault_clear_input;
  logic                  dial_accept, local_mode, edit_refused, fault_free;
  logic                  motor_enable, motor_dir_cw, alarm_led;
  int                    failures = 0;
  int                    n_compared = 0;
  int                    code_m = 0;
  int                    hq[$];
  bit                    alarm_m = 0;
  bit                    nr_m = 0;
  bit                    have = 0;
  bit                    locm = 0;

  mda_host u_host (
    .clock, .sys_rst, .run_sel, .clr_req, .brk,
    .forward_run_input, .reverse_run_input, .fault_clear_input
  );
  mda_top #(.BLINK_COUNT(BL)) u_dut (
    .clock, .sys_rst, .forward_run_input, .reverse_run_input, .fault_clear_input,
    .alarm_detect(stb[0]), .alarm_code_in, .alarm_nonresettable, .info_present,
    .panel_clear_cmd(stb[1]), .soft_clear_cmd(stb[2]), .power_on_clear(stb[3]),
    .panel_hist_clear(stb[4]), .soft_hist_clear(stb[5]), .hist_rd_index,
    .hist_rd_code, .hist_count, .dir_param, .speed_upper, .speed_lower,
    .speed_request, .edit_lock, .panel_edit_enable, .soft_session,
    .dial_write(stb[6]), .dial_value, .local_mode_req(stb[7]), .dial_accept,
    .panel_setting, .local_mode, .edit_refused, .fault_free, .motor_enable,
    .motor_dir_cw, .speed_command, .display_code, .alarm_led
  );

  // ****
  // tasks
  // ****
  task automatic chk(input bit ok, input string m);
    n_compared++;
    if (!ok) begin
      failures++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic pulse(input int b);
    @(posedge clock);
    stb[b] <= 1'b1;
    @(posedge clock);
    stb[b] <= 1'b0;
    #1;
  endtask
  task automatic state_chk();
    chk(fault_free === !alarm_m, "fault free");
    chk(display_code === (alarm_m ? code_m[7:0] : CODE_NONE), "code");
    chk(hist_count === HIST_IDX_W'(hq.size()), "count");
    if (alarm_m) chk(motor_enable === 1'b0, "stop");
  endtask
  task automatic raise(input bit nr);
    int c;
    c = $urandom_range(255, 1);
    @(posedge clock);
    alarm_code_in <= c[7:0];
    alarm_nonresettable <= nr;
    pulse(0);
    if (!alarm_m) begin
      hq.push_front(c);
      if (hq.size() > HIST_DEPTH) void'(hq.pop_back());
      alarm_m = 1;
      nr_m = nr;
      code_m = c;
    end
  endtask
  task automatic strobe_clr(input int b, input bit ok);
    pulse(b);
    if (ok) alarm_m = 0;
    state_chk();
  endtask
  task automatic pin_clr(input bit b);
    @(posedge clock);
    brk <= b;
    clr_req <= 1'b1;
    cyc(12);
    if (!b && !nr_m) alarm_m = 0;
    state_chk();
    @(posedge clock);
    clr_req <= 1'b0;
    cyc(4);
  endtask
  task automatic hist_chk();
    for (int i = 0; i < 12; i++) begin
      @(posedge clock);
      hist_rd_index <= i[3:0];
      cyc(1);
      chk(hist_rd_code === (i < hq.size() ? hq[i][7:0] : 8'h00), "hist");
    end
    chk(hist_count === HIST_IDX_W'(hq.size()), "count");
  endtask
  task automatic led_chk(input bit on);
    int h;
    h = 0;
    repeat (6 * BL) begin
      cyc(1);
      h += (alarm_led === 1'b1);
    end
    chk(on ? (h > 0 && h < 6 * BL) : (h == 0), "led");
  endtask
  task automatic end_sim();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ****
  // stimulus
  // ****
  initial begin
    forever #10 clock = ~clock;
  end
  initial begin
    repeat (20000) @(posedge clock);
    failures++;
    end_sim();
  end
  initial begin
    void'($urandom(21735));
    repeat (10) @(posedge clock);
    sys_rst <= 1'b0;
    cyc(3);
    state_chk();
    led_chk(0);
    for (int i = 0; i < 12; i++) begin
      int u, l, q, e;
      bit run;
      u = $urandom_range(65000, 100);
      l = $urandom_range(u, 0);
      q = $urandom_range(65535, 0);
      @(posedge clock);
      run_sel <= i[1:0];
      speed_upper <= u[15:0];
      speed_lower <= l[15:0];
      speed_request <= q[15:0];
      dir_param <= i[2];
      cyc(6);
      run = i[0] ^ i[1];
      e = q < l ? l : q;
      if (e > u) e = u;
      chk(motor_enable === run, "run");
      chk(speed_command === (run ? e[15:0] : 16'h0000), "speed");
      if (run) chk(motor_dir_cw === (i[2] ? i[0] : i[1]), "dir");
    end
    @(posedge clock);
    run_sel <= 2'd1;
    raise(0);
    state_chk();
    led_chk(1);
    raise(0);
    state_chk();
    pin_clr(1);
    pin_clr(0);
    @(posedge clock);
    clr_req <= 1'b1;
    cyc(12);
    raise(0);
    cyc(10);
    state_chk();
    @(posedge clock);
    clr_req <= 1'b0;
    cyc(4);
    strobe_clr(1, 1);
    raise(0);
    strobe_clr(2, 1);
    raise(1);
    pin_clr(0);
    strobe_clr(1, 0);
    strobe_clr(2, 0);
    strobe_clr(3, 1);
    for (int i = 0; i < 9; i++) begin
      raise(0);
      strobe_clr(2, 1);
    end
    hist_chk();
    strobe_clr(3, 1);
    hist_chk();
    raise(0);
    @(posedge clock);
    sys_rst <= 1'b1;
    repeat (3) @(posedge clock);
    sys_rst <= 1'b0;
    alarm_m = 0;
    cyc(4);
    state_chk();
    hist_chk();
    pulse(4);
    hq.delete();
    hist_chk();
    raise(0);
    strobe_clr(1, 1);
    pulse(5);
    hq.delete();
    hist_chk();
    @(posedge clock);
    info_present <= 1'b1;
    led_chk(1);
    @(posedge clock);
    info_present <= 1'b0;
    cyc(2 * BL);
    led_chk(0);
    for (int k = 0; k < 8; k++) begin
      bit ok;
      ok = !k[0] && k[1] && !k[2];
      @(posedge clock);
      edit_lock <= k[0];
      panel_edit_enable <= k[1];
      soft_session <= k[2];
      dial_value <= 16'($urandom);
      @(posedge clock);
      stb[6] <= 1'b1;
      #1;
      chk(dial_accept === ok, "accept");
      if (ok) set_m = dial_value;
      @(posedge clock);
      stb[6] <= 1'b0;
      #1;
      if (ok) have = 1;
      if (have) chk(panel_setting === set_m, "setting");
      chk(edit_refused === !ok, "refused");
      pulse(7);
      if (!k[2]) locm = !locm;
      chk(local_mode === locm, "local");
      chk(edit_refused === k[2], "local refused");
    end
    end_sim();
  end
endmodule
